// [common/sfr_pkg.sv]
/*
 shared constants, types and helpers for the serial flash fast-read link:
 opcodes, phase lengths, reset values, host register map, command decode.
 assumes both ends and the bench import it whole.
*/
package sfr_pkg;
   localparam logic [7:0] SFR_OP_FAST = 8'h0b;
   localparam logic [7:0] SFR_OP_DUAL_OUT = 8'h3b;
   localparam logic [7:0] SFR_OP_QUAD_OUT = 8'h6b;
   localparam logic [7:0] SFR_OP_DUAL_IO = 8'hbb;
   localparam logic [7:0] SFR_OP_QUAD_IO = 8'heb;
   localparam logic [7:0] SFR_OP_WORD_QUAD = 8'he7;
   localparam logic [7:0] SFR_OP_SET_WRAP = 8'h77;

   localparam logic [4:0] SFR_CMD_CLOCKS = 5'h08;
   localparam logic [5:0] SFR_ADDR_BITS = 6'h18;
   localparam logic [5:0] SFR_MODE_BITS = 6'h08;
   localparam logic [5:0] SFR_BYTE_BITS = 6'h08;
   localparam logic [3:0] SFR_DUMMY_FAST = 4'h8;
   localparam logic [3:0] SFR_DUMMY_QUAD_IO = 4'h4;
   localparam logic [3:0] SFR_DUMMY_WORD = 4'h2;
   localparam logic [3:0] SFR_DUMMY_NONE = 4'h0;
   localparam logic [4:0] SFR_EXIT_DUAL_CLOCKS = 5'h10;
   localparam logic [4:0] SFR_EXIT_QUAD_CLOCKS = 5'h08;
   localparam logic [2:0] SFR_L0 = 3'h0;
   localparam logic [2:0] SFR_L1 = 3'h1;
   localparam logic [2:0] SFR_L2 = 3'h2;
   localparam logic [2:0] SFR_L4 = 3'h4;

   localparam logic [1:0] SFR_SKIP_CODE = 2'h2;
   localparam logic SFR_WRAP_DIS_RST = 1'b1;
   localparam logic [1:0] SFR_WRAP_LEN_RST = 2'h0;
   localparam logic SFR_CONT_RST = 1'b0;

   localparam int SFR_CLK_NS = 10;
   localparam int SFR_SCK_HALF_NS = 60;
   localparam int SFR_SCK_HALF = (SFR_SCK_HALF_NS + SFR_CLK_NS - 1) / SFR_CLK_NS;

   localparam logic [2:0] SFR_REG_CTRL = 3'h0;
   localparam logic [2:0] SFR_REG_ADDR = 3'h1;
   localparam logic [2:0] SFR_REG_MODE = 3'h2;
   localparam logic [2:0] SFR_REG_STATUS = 3'h3;
   localparam logic [2:0] SFR_REG_RX = 3'h4;
   localparam int SFR_CTRL_SKIP = 8;
   localparam int SFR_CTRL_EXIT = 9;
   localparam int SFR_CTRL_EXIT_QUAD = 10;
   localparam int SFR_CTRL_START = 11;

   typedef struct packed {
      logic ok;
      logic [2:0] alanes;
      logic mode;
      logic [3:0] dummy;
      logic [2:0] dlanes;
      logic quad;
      logic setwrap;
      logic wrapok;
   } sfr_fmt_t;

   function automatic sfr_fmt_t sfr_decode(input logic [7:0] op);
      sfr_fmt_t f;
      f = '0;
      case (op)
         SFR_OP_FAST: f = '{1'b1, SFR_L1, 1'b0, SFR_DUMMY_FAST, SFR_L1, 1'b0, 1'b0, 1'b0};
         SFR_OP_DUAL_OUT: f = '{1'b1, SFR_L1, 1'b0, SFR_DUMMY_FAST, SFR_L2, 1'b0, 1'b0, 1'b0};
         SFR_OP_QUAD_OUT: f = '{1'b1, SFR_L1, 1'b0, SFR_DUMMY_FAST, SFR_L4, 1'b1, 1'b0, 1'b0};
         SFR_OP_DUAL_IO: f = '{1'b1, SFR_L2, 1'b1, SFR_DUMMY_NONE, SFR_L2, 1'b0, 1'b0, 1'b0};
         SFR_OP_QUAD_IO: f = '{1'b1, SFR_L4, 1'b1, SFR_DUMMY_QUAD_IO, SFR_L4, 1'b1, 1'b0, 1'b1};
         SFR_OP_WORD_QUAD: f = '{1'b1, SFR_L4, 1'b1, SFR_DUMMY_WORD, SFR_L4, 1'b1, 1'b0, 1'b1};
         SFR_OP_SET_WRAP: f = '{1'b1, SFR_L4, 1'b1, SFR_DUMMY_NONE, SFR_L0, 1'b1, 1'b1, 1'b0};
         default: f = '0;
      endcase
      return f;
   endfunction

   // clocks needed to move a number of bits over a lane count
   function automatic logic [4:0] sfr_clocks(input logic [5:0] bits, input logic [2:0] lanes);
      if (lanes == SFR_L4)
         return 5'(bits >> 2);
      else if (lanes == SFR_L2)
         return 5'(bits >> 1);
      return 5'(bits);
   endfunction

   // msb-first shift of one clock's group, higher lanes carry higher bits
   function automatic logic [31:0] sfr_shift_in(input logic [31:0] acc, input logic [3:0] io,
                                                input logic [2:0] lanes, input logic from_io1);
      if (lanes == SFR_L4)
         return {acc[27:0], io};
      else if (lanes == SFR_L2)
         return {acc[29:0], io[1:0]};
      return {acc[30:0], from_io1 ? io[1] : io[0]};
   endfunction

   function automatic logic [23:0] sfr_next_addr(input logic [23:0] a, input logic wrap_on,
                                                 input logic [1:0] len);
      logic [7:0] m;
      logic [23:0] inc;
      m = 8'((9'h008 << len) - 9'h001);
      inc = a + 24'h000001;
      if (wrap_on)
         return (a & ~{16'h0000, m}) | (inc & {16'h0000, m});
      return inc;
   endfunction
endpackage

// [common/sfr_spi_if.sv]
/*
 the spi link between flash device end and host end, with wire resolution.
 assumes an undriven io line floats high through a pull-up.
*/
`timescale 1ns/1ps
interface sfr_spi_if;
   logic cs_n;
   logic sck;
   logic [3:0] host_o;
   logic [3:0] host_oe;
   logic [3:0] dev_o;
   logic [3:0] dev_oe;
   logic [3:0] io;

   always_comb
   begin
      for (int i = 0; i < 4; i++)
         io[i] = host_oe[i] ? host_o[i] : (dev_oe[i] ? dev_o[i] : 1'b1);
   end

   modport dev (input cs_n, input sck, input io, output dev_o, output dev_oe);
   modport host (output cs_n, output sck, output host_o, output host_oe, input io);
endinterface

// [rtl/sfr_flash_dev.sv]
/*
 device end: read-command front end of a serial flash, single/dual/quad lanes,
 continuous read, wrap setting and wrapped bursts.
 assumes spi mode 0 from the host, sck slow enough to be oversampled by CLOCK,
 and a memory that shows MEM_DATA for MEM_ADDR within one CLOCK cycle.
*/
`timescale 1ns/1ps
// How it works
// - fast read: 24-bit address, eight dummies
// - dual output read drives IO0 and IO1
// - 3Bh/6Bh: eight ignored dummy clocks after address
// - host releases lanes before first data
// - 6Bh needs quad permit, four data lanes
// - BBh address and data on two lanes
// - mode byte follows address; low nibble ignored
// - BBh skip code 10 omits next opcode
// - other skip code restores opcode next time
// - host exits dual continuous: ones, 16 clocks
// - host exits quad continuous: ones, 8 clocks
// - EBh: quad address, mode, four dummies
// - EBh only with quad permit
// - EBh skip code 10 omits next opcode
// - wrap keeps data in aligned section
// - 77h sets wrap for later EBh/E7h reads
// - wrap byte: disable bit, length field
// - host gives even address for E7h
// - E7h: only two dummy clocks
// - E7h only with quad permit
// - address increments per byte, msb first
// - length codes 8..64; disable resets to one
module sfr_flash_dev
   import sfr_pkg::*;
(
   input wire logic CLOCK,
   input wire logic RST_N,
   sfr_spi_if.dev BUS,
   input wire logic QUAD_PERMIT,
   output logic [23:0] MEM_ADDR,
   input wire logic [7:0] MEM_DATA,
   output logic CONT_MODE,
   output logic WRAP_DISABLE,
   output logic [1:0] WRAP_LENGTH,
   output logic READ_ACTIVE
);
   typedef enum logic [6:0] {
      D_IDLE = 7'h01,
      D_CMD = 7'h02,
      D_ADDR = 7'h04,
      D_MODE = 7'h08,
      D_DUMMY = 7'h10,
      D_DATA = 7'h20,
      D_IGN = 7'h40
   } sfr_dstate_t;

   sfr_dstate_t state_q;
   sfr_fmt_t fmt_q;
   sfr_fmt_t dec;
   logic [7:0] op_q;
   logic [4:0] cnt_q;
   logic [4:0] need;
   logic last;
   logic [31:0] acc_q;
   logic [31:0] acc_nx;
   logic [2:0] lanes_in;
   logic [2:0] sck_sq;
   logic [1:0] cs_sq;
   logic [3:0] io_s1_q;
   logic [3:0] io_s2_q;
   logic rise;
   logic fall;
   logic cont_q;
   logic [7:0] cont_op_q;
   logic wrap_dis_q;
   logic [1:0] wrap_len_q;
   logic [23:0] mem_addr_q;
   logic [7:0] sh_q;
   logic [7:0] byte_cur;
   logic [4:0] grp_q;
   logic [4:0] grp_need;
   logic [3:0] dout_q;
   logic [3:0] doe_q;

   // two-stage input synchronisers, third sck stage for edge finding
   always_ff @(posedge CLOCK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         sck_sq <= 3'h0;
         cs_sq <= 2'h3;
         io_s1_q <= 4'hf;
         io_s2_q <= 4'hf;
      end
      else
      begin
         sck_sq <= {sck_sq[1:0], BUS.sck};
         cs_sq <= {cs_sq[0], BUS.cs_n};
         io_s1_q <= BUS.io;
         io_s2_q <= io_s1_q;
      end
   end

   assign rise = sck_sq[1] & ~sck_sq[2] & ~cs_sq[1];
   assign fall = ~sck_sq[1] & sck_sq[2] & ~cs_sq[1];

   always_comb
   begin
      lanes_in = (state_q == D_CMD) ? SFR_L1 : fmt_q.alanes;
      acc_nx = sfr_shift_in(acc_q, io_s2_q, lanes_in, 1'b0);
      dec = sfr_decode(acc_nx[7:0]);
      case (state_q)
         D_CMD: need = SFR_CMD_CLOCKS;
         D_ADDR: need = sfr_clocks(SFR_ADDR_BITS, fmt_q.alanes);
         D_MODE: need = sfr_clocks(SFR_MODE_BITS, fmt_q.alanes);
         D_DUMMY: need = {1'b0, fmt_q.dummy};
         default: need = 5'h01;
      endcase
      last = (cnt_q == need - 5'h01);
      grp_need = sfr_clocks(SFR_BYTE_BITS, fmt_q.dlanes);
      byte_cur = (grp_q == 5'h00) ? MEM_DATA : sh_q;
   end

   // phase sequencing on sampled sck rising edges
   always_ff @(posedge CLOCK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         state_q <= D_IDLE;
         cnt_q <= 5'h00;
         fmt_q <= '0;
         op_q <= 8'h00;
      end
      else if (cs_sq[1])
      begin
         state_q <= D_IDLE;
         cnt_q <= 5'h00;
      end
      else
      begin
         if (rise && (state_q == D_CMD || state_q == D_ADDR || state_q == D_MODE || state_q == D_DUMMY))
            cnt_q <= last ? 5'h00 : cnt_q + 5'h01;
         case (state_q)
            D_IDLE:
            begin
               cnt_q <= 5'h00;
               if (cont_q)
               begin
                  state_q <= D_ADDR;
                  fmt_q <= sfr_decode(cont_op_q);
                  op_q <= cont_op_q;
               end
               else
                  state_q <= D_CMD;
            end
            D_CMD:
               if (rise && last)
               begin
                  if (!dec.ok || (dec.quad && !QUAD_PERMIT))
                     state_q <= D_IGN;
                  else
                     state_q <= D_ADDR;
                  fmt_q <= dec;
                  op_q <= acc_nx[7:0];
               end
            D_ADDR:
               if (rise && last)
               begin
                  if (fmt_q.mode)
                     state_q <= D_MODE;
                  else if (fmt_q.dummy != SFR_DUMMY_NONE)
                     state_q <= D_DUMMY;
                  else
                     state_q <= D_DATA;
               end
            D_MODE:
               if (rise && last)
               begin
                  if (fmt_q.setwrap)
                     state_q <= D_IGN;
                  else if (fmt_q.dummy != SFR_DUMMY_NONE)
                     state_q <= D_DUMMY;
                  else
                     state_q <= D_DATA;
               end
            D_DUMMY:
               if (rise && last)
                  state_q <= D_DATA;
            default:
               state_q <= state_q;
         endcase
      end
   end

   // input shifter, host data during dummies is never shifted
   always_ff @(posedge CLOCK or negedge RST_N)
   begin
      if (!RST_N)
         acc_q <= 32'h00000000;
      else if (state_q == D_IDLE)
         acc_q <= 32'h00000000;
      else if (rise && (state_q == D_CMD || state_q == D_ADDR || state_q == D_MODE))
         acc_q <= acc_nx;
   end

   // continuous read and wrap settings from the mode byte
   always_ff @(posedge CLOCK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         cont_q <= SFR_CONT_RST;
         cont_op_q <= 8'h00;
         wrap_dis_q <= SFR_WRAP_DIS_RST;
         wrap_len_q <= SFR_WRAP_LEN_RST;
      end
      else if (state_q == D_MODE && rise && last)
      begin
         if (fmt_q.setwrap)
         begin
            wrap_dis_q <= acc_nx[4];
            wrap_len_q <= acc_nx[6:5];
         end
         else
         begin
            cont_q <= (acc_nx[5:4] == SFR_SKIP_CODE);
            cont_op_q <= op_q;
         end
      end
   end

   // read address: loaded after address phase, stepped per byte
   always_ff @(posedge CLOCK or negedge RST_N)
   begin
      if (!RST_N)
         mem_addr_q <= 24'h000000;
      else if (state_q == D_ADDR && rise && last)
         mem_addr_q <= acc_nx[23:0];
      else if (state_q == D_DATA && fall && grp_q == 5'h00)
         mem_addr_q <= sfr_next_addr(mem_addr_q, fmt_q.wrapok & ~wrap_dis_q, wrap_len_q);
   end

   // data out on sck falling edges
   always_ff @(posedge CLOCK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         dout_q <= 4'h0;
         doe_q <= 4'h0;
         sh_q <= 8'h00;
         grp_q <= 5'h00;
      end
      else if (state_q != D_DATA)
      begin
         doe_q <= 4'h0;
         grp_q <= 5'h00;
      end
      else if (fall)
      begin
         grp_q <= (grp_q == grp_need - 5'h01) ? 5'h00 : grp_q + 5'h01;
         if (fmt_q.dlanes == SFR_L4)
         begin
            dout_q <= byte_cur[7:4];
            doe_q <= 4'hf;
            sh_q <= {byte_cur[3:0], 4'h0};
         end
         else if (fmt_q.dlanes == SFR_L2)
         begin
            dout_q <= {2'h0, byte_cur[7:6]};
            doe_q <= 4'h3;
            sh_q <= {byte_cur[5:0], 2'h0};
         end
         else
         begin
            dout_q <= {2'h0, byte_cur[7], 1'b0};
            doe_q <= 4'h2;
            sh_q <= {byte_cur[6:0], 1'b0};
         end
      end
   end

   assign BUS.dev_o = dout_q;
   assign BUS.dev_oe = doe_q;
   assign MEM_ADDR = mem_addr_q;
   assign CONT_MODE = cont_q;
   assign WRAP_DISABLE = wrap_dis_q;
   assign WRAP_LENGTH = wrap_len_q;
   assign READ_ACTIVE = (state_q == D_DATA);
endmodule

// [rtl/sfr_flash_host.sv]
/*
 host end: spi controller for the flash read commands, driven by registers.
 assumes the device follows spi mode 0; sck is made here by a divider.
*/
`timescale 1ns/1ps
module sfr_flash_host
   import sfr_pkg::*;
#(
   parameter int SCK_HALF = SFR_SCK_HALF
)
(
   input wire logic CLOCK,
   input wire logic RST_N,
   input wire logic [2:0] REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [31:0] REG_RDATA,
   sfr_spi_if.host BUS
);
   typedef enum logic [8:0] {
      H_IDLE = 9'h001,
      H_CMD = 9'h002,
      H_ADDR = 9'h004,
      H_MODE = 9'h008,
      H_DUMMY = 9'h010,
      H_DATA = 9'h020,
      H_EXIT = 9'h040,
      H_END = 9'h080,
      H_GAP = 9'h100
   } sfr_hstate_t;

   sfr_hstate_t state_q;
   sfr_fmt_t fmt;
   logic [7:0] op_q;
   logic skip_q;
   logic exit_q;
   logic exitq_q;
   logic [23:0] addr_q;
   logic [23:0] addr_eff;
   logic [7:0] mode_q;
   logic [7:0] nbytes_q;
   logic done_q;
   logic [7:0] rxcnt_q;
   logic [31:0] rxword_q;
   logic [7:0] rxb_q;
   logic [7:0] rx_nx;
   logic [31:0] rdata_q;
   logic [15:0] div_q;
   logic tick;
   logic act;
   logic sck_q;
   logic cs_n_q;
   logic hrise;
   logic hfall;
   logic start;
   logic drive_q;
   logic [31:0] tx_q;
   logic [2:0] lanes_out;
   logic [4:0] cnt_q;
   logic [4:0] need;
   logic last;
   logic [3:0] out_q;
   logic [3:0] oe_q;
   logic [3:0] io_s1_q;
   logic [3:0] io_s2_q;

   always_comb
   begin
      fmt = sfr_decode(op_q);
      addr_eff = (op_q == SFR_OP_WORD_QUAD) ? {addr_q[23:1], 1'b0} : addr_q;
      tick = (div_q == 16'(SCK_HALF - 1));
      act = state_q != H_IDLE && state_q != H_GAP;
      hrise = tick & ~sck_q & act & (state_q != H_END);
      hfall = tick & sck_q & act;
      start = REG_WR && REG_ADDR == SFR_REG_CTRL && REG_WDATA[SFR_CTRL_START] && state_q == H_IDLE;
      lanes_out = (state_q == H_CMD || state_q == H_EXIT) ? SFR_L1 : fmt.alanes;
      rx_nx = 8'(sfr_shift_in({24'h000000, rxb_q}, io_s2_q, fmt.dlanes, 1'b1));
      case (state_q)
         H_CMD: need = SFR_CMD_CLOCKS;
         H_ADDR: need = sfr_clocks(SFR_ADDR_BITS, fmt.alanes);
         H_MODE: need = sfr_clocks(SFR_MODE_BITS, fmt.alanes);
         H_DUMMY: need = {1'b0, fmt.dummy};
         H_DATA: need = sfr_clocks(SFR_BYTE_BITS, fmt.dlanes);
         H_EXIT: need = exitq_q ? SFR_EXIT_QUAD_CLOCKS : SFR_EXIT_DUAL_CLOCKS;
         default: need = 5'h01;
      endcase
      last = (cnt_q == need - 5'h01);
   end

   always_ff @(posedge CLOCK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         io_s1_q <= 4'hf;
         io_s2_q <= 4'hf;
         div_q <= 16'h0000;
         sck_q <= 1'b0;
      end
      else
      begin
         io_s1_q <= BUS.io;
         io_s2_q <= io_s1_q;
         div_q <= (start || tick) ? 16'h0000 : div_q + 16'h0001;
         if (tick && act)
            sck_q <= ~sck_q;
      end
   end

   // registers seen by software
   always_ff @(posedge CLOCK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         op_q <= 8'h00;
         skip_q <= 1'b0;
         exit_q <= 1'b0;
         exitq_q <= 1'b0;
         addr_q <= 24'h000000;
         mode_q <= 8'h00;
         nbytes_q <= 8'h01;
         rdata_q <= 32'h00000000;
      end
      else
      begin
         if (REG_WR && state_q == H_IDLE)
         begin
            if (REG_ADDR == SFR_REG_CTRL)
            begin
               op_q <= REG_WDATA[7:0];
               skip_q <= REG_WDATA[SFR_CTRL_SKIP];
               exit_q <= REG_WDATA[SFR_CTRL_EXIT];
               exitq_q <= REG_WDATA[SFR_CTRL_EXIT_QUAD];
            end
            else if (REG_ADDR == SFR_REG_ADDR)
               addr_q <= REG_WDATA[23:0];
            else if (REG_ADDR == SFR_REG_MODE)
            begin
               mode_q <= REG_WDATA[7:0];
               nbytes_q <= REG_WDATA[15:8];
            end
         end
         if (!REG_RD)
            rdata_q <= 32'h00000000;
         else if (REG_ADDR == SFR_REG_CTRL)
            rdata_q <= {21'h000000, exitq_q, exit_q, skip_q, op_q};
         else if (REG_ADDR == SFR_REG_ADDR)
            rdata_q <= {8'h00, addr_q};
         else if (REG_ADDR == SFR_REG_MODE)
            rdata_q <= {16'h0000, nbytes_q, mode_q};
         else if (REG_ADDR == SFR_REG_STATUS)
            rdata_q <= {16'h0000, rxcnt_q, 6'h00, done_q, act | (state_q == H_GAP)};
         else if (REG_ADDR == SFR_REG_RX)
            rdata_q <= rxword_q;
         else
            rdata_q <= 32'h00000000;
      end
   end

   // transfer sequencing, outputs change on falls, lanes released on the last address or mode rise, inputs taken on rises
   always_ff @(posedge CLOCK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         state_q <= H_IDLE;
         cs_n_q <= 1'b1;
         cnt_q <= 5'h00;
         tx_q <= 32'h00000000;
         drive_q <= 1'b0;
         out_q <= 4'h0;
         oe_q <= 4'h0;
         done_q <= 1'b0;
         rxcnt_q <= 8'h00;
         rxb_q <= 8'h00;
         rxword_q <= 32'h00000000;
      end
      else
      begin
         drive_q <= start;
         if (start)
         begin
            cs_n_q <= 1'b0;
            done_q <= 1'b0;
            rxcnt_q <= 8'h00;
            cnt_q <= 5'h00;
            if (REG_WDATA[SFR_CTRL_EXIT])
            begin
               state_q <= H_EXIT;
               tx_q <= 32'hffffffff;
            end
            else if (REG_WDATA[SFR_CTRL_SKIP])
            begin
               state_q <= H_ADDR;
               tx_q <= {addr_eff, 8'h00};
            end
            else
            begin
               state_q <= H_CMD;
               tx_q <= {REG_WDATA[7:0], 24'h000000};
            end
         end
         else if ((hfall || drive_q) && state_q != H_END)
         begin
            if (state_q == H_CMD || state_q == H_EXIT)
            begin
               out_q <= {3'h0, tx_q[31]};
               oe_q <= 4'h1;
               tx_q <= {tx_q[30:0], 1'b0};
            end
            else if (state_q == H_ADDR || state_q == H_MODE)
            begin
               if (lanes_out == SFR_L4)
               begin
                  out_q <= tx_q[31:28];
                  oe_q <= 4'hf;
               end
               else if (lanes_out == SFR_L2)
               begin
                  out_q <= {2'h0, tx_q[31:30]};
                  oe_q <= 4'h3;
               end
               else
               begin
                  out_q <= {3'h0, tx_q[31]};
                  oe_q <= 4'h1;
               end
               tx_q <= sfr_shift_in(tx_q, 4'h0, lanes_out, 1'b0) & ~32'h0000000f;
            end
         end
         else if (hfall)
         begin
            cs_n_q <= 1'b1;
            oe_q <= 4'h0;
            state_q <= H_GAP;
         end
         else if (state_q == H_GAP && tick)
         begin
            state_q <= H_IDLE;
            done_q <= 1'b1;
         end
         if (hrise)
         begin
            cnt_q <= last ? 5'h00 : cnt_q + 5'h01;
            if (state_q == H_DATA)
            begin
               rxb_q <= rx_nx;
               if (last)
               begin
                  rxword_q <= {rxword_q[23:0], rx_nx};
                  rxcnt_q <= rxcnt_q + 8'h01;
                  if (8'(rxcnt_q + 8'h01) == nbytes_q)
                     state_q <= H_END;
               end
            end
            else if (last)
            begin
               if (state_q == H_CMD)
               begin
                  state_q <= fmt.ok ? H_ADDR : H_END;
                  tx_q <= {addr_eff, 8'h00};
               end
               else if (state_q == H_ADDR && fmt.mode)
               begin
                  state_q <= H_MODE;
                  tx_q <= {mode_q, 24'h000000};
               end
               else if ((state_q == H_ADDR || state_q == H_MODE) && fmt.dlanes != SFR_L0)
               begin
                  state_q <= (fmt.dummy != SFR_DUMMY_NONE) ? H_DUMMY : H_DATA;
                  oe_q <= 4'h0;
               end
               else if (state_q == H_DUMMY)
                  state_q <= H_DATA;
               else
                  state_q <= H_END;
            end
         end
      end
   end

   assign BUS.cs_n = cs_n_q;
   assign BUS.sck = sck_q;
   assign BUS.host_o = out_q;
   assign BUS.host_oe = oe_q;
   assign REG_RDATA = rdata_q;
endmodule

// [sim/sfr_link_props.sv]
/* checker on the link wires between the two ends.
 assumes one CLOCK domain, RST_N async low. */
`timescale 1ns/1ps
module sfr_link_props (
   input wire logic CLOCK,
   input wire logic RST_N,
   input wire logic cs_n,
   input wire logic sck,
   input wire logic [3:0] host_o,
   input wire logic [3:0] host_oe,
   input wire logic [3:0] dev_o,
   input wire logic [3:0] dev_oe,
   input wire logic [3:0] io
);
   default clocking @(posedge CLOCK);
   endclocking
   default disable iff (!RST_N);
   sck_idle_a: assert property (cs_n |-> !sck) else $error("sck idle");
   cs_lead_a: assert property ($fell(cs_n) |-> !sck [*3]) else $error("cs lead");
   no_fight_a: assert property ((host_oe & dev_oe) == 4'h0) else $error("lane fight");
   dev_quiet_a: assert property ($rose(cs_n) |-> ##[0:6] dev_oe == 4'h0) else $error("dev hold");
   lane_set_a: assert property (dev_oe inside {4'h0, 4'h2, 4'h3, 4'hf}) else $error("lanes");
   dev_edge_a: assert property ($changed(dev_o) && |dev_oe |-> !sck) else $error("dev edge");
   oe_edge_a: assert property ($changed(dev_oe) |-> !sck) else $error("oe edge");
   host_edge_a: assert property (sck && $past(sck) |-> $stable(host_o)) else $error("host edge");
   cover property ($rose(dev_oe == 4'hf));
   cover property ($rose(dev_oe == 4'h3));
   cover property ($rose(dev_oe == 4'h2));
   cover property (!cs_n && dev_oe == 4'hf && io == dev_o);
endmodule

// [sim/sfr_tb_top.sv]
/* bench: host and device ends joined by the link, reads of every opcode.
 assumes memory data is a pure function of the address. */
`timescale 1ns/1ps
module sfr_tb_top
   import sfr_pkg::*;
   ;
   logic CLOCK, RST_N = 1'b0, wr = 1'b0, rd = 1'b0, qp = 1'b1, cont, wdis, ract;
   logic [1:0] wlen;
   logic [2:0] ra = '0;
   logic [31:0] wd = '0, rdat, got;
   logic [23:0] maddr;
   int err_count = 0, comparisons = 0, cyc = 0;
   sfr_spi_if spi();
   sfr_flash_host #(.SCK_HALF(SFR_SCK_HALF)) u_sfr_flash_host (.CLOCK(CLOCK), .RST_N(RST_N), .REG_ADDR(ra),
      .REG_WDATA(wd), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdat), .BUS(spi));
   sfr_flash_dev u_sfr_flash_dev (.CLOCK(CLOCK), .RST_N(RST_N), .BUS(spi), .QUAD_PERMIT(qp), .MEM_ADDR(maddr),
      .MEM_DATA(mem(maddr)), .CONT_MODE(cont), .WRAP_DISABLE(wdis), .WRAP_LENGTH(wlen), .READ_ACTIVE(ract));
   sfr_link_props u_sfr_link_props (.CLOCK(CLOCK), .RST_N(RST_N), .cs_n(spi.cs_n), .sck(spi.sck),
      .host_o(spi.host_o), .host_oe(spi.host_oe), .dev_o(spi.dev_o), .dev_oe(spi.dev_oe), .io(spi.io));
   function automatic logic [7:0] mem(input logic [23:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h3c;
   endfunction
   // four bytes from a, newest lowest, wrapped within the section if w
   function automatic logic [31:0] exp_rx(input logic [23:0] a, input logic w, input logic [1:0] l);
      logic [31:0] r;
      logic [23:0] m;
      r = '0;
      m = (24'h8 << l) - 24'h1;
      for (int i = 0; i < 4; i++)
         r = {r[23:0], mem(w ? (a & ~m) | ((a + 24'(i)) & m) : a + 24'(i))};
      return r;
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e)
      begin
         err_count++;
         $display("ERROR t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
      @(posedge CLOCK);
      ra <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      @(posedge CLOCK);
      wr <= 1'b0;
      rd <= 1'b0;
      #1 got = rdat;
   endtask
   task automatic run(input logic [7:0] op, input logic [2:0] fl, input logic [23:0] a, input logic [7:0] md);
      bus(1'b1, SFR_REG_ADDR, {8'h00, a});
      bus(1'b1, SFR_REG_MODE, {16'h0004, md});
      bus(1'b1, SFR_REG_CTRL, {20'h0, 1'b1, fl, op});
      for (int i = 0; i < 4000 && got[1] !== 1'b1; i++)
         bus(1'b0, SFR_REG_STATUS, '0);
      chk(32'({got[1], ract}), 32'h2);
      bus(1'b0, SFR_REG_RX, '0);
   endtask
   task automatic tally_and_finish();
      $display("compares %0d errors %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial
   begin
      CLOCK = 1'b0;
      forever #5 CLOCK = ~CLOCK;
   end
   always @(posedge CLOCK)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         err_count++;
         tally_and_finish();
      end
   end
   initial
   begin
      logic [23:0] a;
      logic [7:0] ops [6] = '{SFR_OP_FAST, SFR_OP_DUAL_OUT, SFR_OP_QUAD_OUT, SFR_OP_DUAL_IO, SFR_OP_QUAD_IO,
         SFR_OP_WORD_QUAD};
      void'($urandom(32'hed87));
      repeat (6) @(posedge CLOCK);
      RST_N <= 1'b1;
      chk(32'({wdis, wlen}), 32'h4);
      foreach (ops[i])
      begin
         a = 24'($urandom);
         run(ops[i], 3'h0, a, 8'hff);
         chk(got, exp_rx(i == 5 ? a & 24'hfffffe : a, 1'b0, 2'h0));
      end
      @(posedge CLOCK);
      qp <= 1'b0;
      for (int i = 2; i < 6; i++)
      begin
         run(ops[i], 3'h0, 24'h000010, 8'hff);
         chk(got, i == 3 ? exp_rx(24'h000010, 1'b0, 2'h0) : 32'hffffffff);
      end
      @(posedge CLOCK);
      qp <= 1'b1;
      for (int i = 3; i < 5; i++)
      begin
         a = 24'($urandom) & 24'hfffffe;
         run(ops[i], 3'h0, a, 8'ha5);
         chk(32'(cont), 32'h1);
         run(ops[i], 3'h1, a + 24'h40, 8'hff);
         chk(got, exp_rx(a + 24'h40, 1'b0, 2'h0));
         chk(32'(cont), 32'h0);
         run(ops[i], 3'h0, a, 8'h2f);
         run(ops[i], {i == 4, 2'h2}, a, 8'hff);
         chk(32'(cont), 32'h0);
         run(ops[i], 3'h0, a, 8'hff);
         chk(got, exp_rx(a, 1'b0, 2'h0));
      end
      for (int l = 0; l < 4; l++)
      begin
         run(SFR_OP_SET_WRAP, 3'h0, 24'h0, {1'b0, 2'(l), 5'h00});
         chk(32'({wdis, wlen}), 32'(l));
         a = {16'($urandom), 8'hfe};
         run(ops[4 + l % 2], 3'h0, a, 8'hff);
         chk(got, exp_rx(a, 1'b1, 2'(l)));
      end
      tally_and_finish();
   end
endmodule
